// ==== rtl/fpa_pkg.sv ====
// Purpose: constants and carriers for the fan channel two source arbiter
// Assumes: 8-bit register port inside the chip, 4-bit duty codes
// Notes:   code 4'hf is the full 100% duty level
package fpa_pkg;

  localparam int unsigned CODE_W = 4;
  localparam int unsigned NUM_SRC = 8;

  // register offsets
  localparam logic [7:0] SOURCE_SELECT_ADDR   = 8'h00_cc;
  localparam logic [7:0] OVERRIDE_LOCK_ADDR   = 8'h00_cd;
  localparam logic [7:0] SOURCE_SELECT_RESET  = 8'h00_00;
  localparam logic [7:0] OVERRIDE_LOCK_RESET  = 8'h00_00;

  // source-select bit positions
  localparam int unsigned BIND_ZONE_TABLE_ONE      = 0;
  localparam int unsigned BIND_ZONE_TABLE_FOUR     = 3;
  localparam int unsigned BIND_CPU1_THERMAL_ALERT  = 4;
  localparam int unsigned BIND_CPU2_THERMAL_ALERT  = 5;
  localparam int unsigned BIND_REGULATOR1_OVERTEMP = 6;
  localparam int unsigned BIND_REGULATOR2_OVERTEMP = 7;

  // override-and-lock bit positions
  localparam int unsigned MANUAL_DUTY_FORCE     = 0;
  localparam int unsigned OUTPUT_POLARITY_FLIP  = 1;
  localparam int unsigned HOT_EVENT_HOLD_ENABLE = 2;
  localparam int unsigned HOT_EVENT_FULL_HOLD   = 3;
  localparam int unsigned MANUAL_DUTY_LEVEL_LO  = 4;
  localparam int unsigned MANUAL_DUTY_LEVEL_HI  = 7;

  localparam logic [3:0] DUTY_FULL = 4'h000f;
  localparam logic [3:0] DUTY_ZERO = 4'h0000;

  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] data;
  } fpa_reg_wr_s;

  typedef struct packed {
    logic       rd_en;
    logic [7:0] addr;
  } fpa_reg_rd_s;

endpackage

// ==== rtl/fpa_source_arbiter.sv ====
// Purpose: source binding, largest-duty arbitration, manual override,
//          hot-event hold and polarity for fan drive channel two
// Assumes: table, ramp and spin-up requests come from neighbouring blocks;
//          all inputs synchronous to ref_clk_i
// Notes:   pin waveform uses a 16-step phase advanced by pwm_step_tick_i
//
// How it works
// - source-select bits 0..3 bind the channel to zone tables one to four.
// - bits 4 and 5 bind the channel to cpu thermal alerts one and two.
// - bits 6 and 7 bind the channel to regulator overtemp inputs.
// - bound zone tables request duty via their table lookup code.
// - bound alert and overtemp inputs request duty via ramp codes.
// - channel uses the largest duty requested among bound sources.
// - control-2 bit 0 enables the manual duty override.
// - polarity bit clear gives high at full duty, set gives low.
// - hold status sets on bound cpu alert only while hold enable set.
// - channel stays at full duty while hold status is set.
// - software writes zero to clear hold; channel returns to sources.
// - hold status stays writable while configuration freeze is set.
// - manual level field 7:4 competes with the bound sources as a duty request under override.
// - reading the level field returns the duty code in use.
// - level field reads zero while spin-up is active.
// - duty change from zero to non-zero starts the spin-up sequence.
`timescale 1ns/100ps
`default_nettype none

module fpa_source_arbiter #(
  parameter int unsigned CODE_W = fpa_pkg::CODE_W
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_b_i,
  input  wire fpa_pkg::fpa_reg_wr_s  reg_wr_i,
  input  wire fpa_pkg::fpa_reg_rd_s  reg_rd_i,
  output logic [7:0]                 reg_rd_data_o,
  output logic                       reg_rd_hit_o,
  input  wire logic                  config_freeze_i,
  input  wire logic [CODE_W-1:0]     zone_table_duty_i [4],
  input  wire logic [CODE_W-1:0]     cpu1_ramp_duty_i,
  input  wire logic [CODE_W-1:0]     cpu2_ramp_duty_i,
  input  wire logic [CODE_W-1:0]     regulator1_ramp_duty_i,
  input  wire logic [CODE_W-1:0]     regulator2_ramp_duty_i,
  input  wire logic                  cpu1_thermal_alert_in_b_i,
  input  wire logic                  cpu2_thermal_alert_in_b_i,
  input  wire logic                  spin_up_active_i,
  input  wire logic [CODE_W-1:0]     spin_up_duty_i,
  input  wire logic                  pwm_step_tick_i,
  output logic                       spin_up_start_o,
  output logic [CODE_W-1:0]          duty_in_use_o,
  output logic                       fan_drive_channel_two_o
);

  function automatic logic [CODE_W-1:0] larger(input logic [CODE_W-1:0] a,
                                               input logic [CODE_W-1:0] b);
    larger = (a > b) ? a : b;
  endfunction

  // one-hot decode shared by the write and read paths
  function automatic logic [1:0] reg_decode(input logic [7:0] addr);
    reg_decode = 2'b00;
    if (addr == fpa_pkg::SOURCE_SELECT_ADDR) begin
      reg_decode = 2'b01;
    end else if (addr == fpa_pkg::OVERRIDE_LOCK_ADDR) begin
      reg_decode = 2'b10;
    end
  endfunction

  logic [7:0]        source_select_reg;
  logic              manual_duty_force_reg;
  logic              output_polarity_flip_reg;
  logic              hot_event_hold_enable_reg;
  logic              hot_event_full_hold_reg;
  logic              hot_event_full_hold_next;
  logic [CODE_W-1:0] manual_duty_level_reg;
  logic [CODE_W-1:0] duty_in_use_reg;
  logic [CODE_W-1:0] duty_in_use_next;
  logic [CODE_W-1:0] phase_reg;
  logic              spin_up_start_reg;
  logic              drive_reg;
  logic [7:0]        rd_data_reg;
  logic              rd_hit_reg;

  wire [1:0] wr_dec = reg_decode(reg_wr_i.addr);
  wire [1:0] rd_dec = reg_decode(reg_rd_i.addr);
  wire wr_select = reg_wr_i.wr_en && wr_dec[0];
  wire wr_ctrl   = reg_wr_i.wr_en && wr_dec[1];
  // freeze guards configuration but never the hold status bit
  wire wr_select_ok = wr_select && !config_freeze_i;
  wire wr_ctrl_ok   = wr_ctrl && !config_freeze_i;
  wire hold_clear   = wr_ctrl && !reg_wr_i.data[fpa_pkg::HOT_EVENT_FULL_HOLD];

  // source request codes in source-select bit order
  logic [CODE_W-1:0] src_req    [fpa_pkg::NUM_SRC];
  logic [CODE_W-1:0] src_masked [fpa_pkg::NUM_SRC];

  assign src_req[0] = zone_table_duty_i[0];
  assign src_req[1] = zone_table_duty_i[1];
  assign src_req[2] = zone_table_duty_i[2];
  assign src_req[3] = zone_table_duty_i[3];
  assign src_req[fpa_pkg::BIND_CPU1_THERMAL_ALERT]  = cpu1_ramp_duty_i;
  assign src_req[fpa_pkg::BIND_CPU2_THERMAL_ALERT]  = cpu2_ramp_duty_i;
  assign src_req[fpa_pkg::BIND_REGULATOR1_OVERTEMP] = regulator1_ramp_duty_i;
  assign src_req[fpa_pkg::BIND_REGULATOR2_OVERTEMP] = regulator2_ramp_duty_i;

  // unbound sources request zero so they cannot win the compare
  genvar gi;
  generate
    for (gi = 0; gi < fpa_pkg::NUM_SRC; gi++) begin : g_bind
      assign src_masked[gi] = source_select_reg[gi] ? src_req[gi] : '0;
    end
  endgenerate

  logic [CODE_W-1:0] src_max;
  always_comb begin
    src_max = '0;
    for (int i = 0; i < fpa_pkg::NUM_SRC; i++) begin
      src_max = larger(src_max, src_masked[i]);
    end
  end

  // manual level competes with the sources rather than replacing them
  wire [CODE_W-1:0] with_manual =
    manual_duty_force_reg ? larger(src_max, manual_duty_level_reg) : src_max;

  wire cpu_alert_event =
    (source_select_reg[fpa_pkg::BIND_CPU1_THERMAL_ALERT] && !cpu1_thermal_alert_in_b_i) ||
    (source_select_reg[fpa_pkg::BIND_CPU2_THERMAL_ALERT] && !cpu2_thermal_alert_in_b_i);

  // set wins over a clearing write in the same cycle
  always_comb begin
    hot_event_full_hold_next = hot_event_full_hold_reg;
    if (hold_clear) begin
      hot_event_full_hold_next = 1'b0;
    end
    if (hot_event_hold_enable_reg && cpu_alert_event) begin
      hot_event_full_hold_next = 1'b1;
    end
  end

  always_comb begin
    if (hot_event_full_hold_reg) begin
      duty_in_use_next = fpa_pkg::DUTY_FULL;
    end else if (spin_up_active_i) begin
      duty_in_use_next = larger(spin_up_duty_i, with_manual);
    end else begin
      duty_in_use_next = with_manual;
    end
  end

  wire start_spin = (duty_in_use_reg == '0) && (duty_in_use_next != '0);

  // 16-step pin waveform; the full code is held solid, never a glitch
  wire duty_high = (duty_in_use_reg == fpa_pkg::DUTY_FULL) || (phase_reg < duty_in_use_reg);

  wire [CODE_W-1:0] level_readback = spin_up_active_i ? '0 : duty_in_use_reg;
  wire [7:0] ctrl_readback = {level_readback, hot_event_full_hold_reg,
                              hot_event_hold_enable_reg, output_polarity_flip_reg,
                              manual_duty_force_reg};
  wire rd_select = rd_dec[0];
  wire rd_ctrl   = rd_dec[1];
  wire [7:0] rd_mux = rd_select ? source_select_reg : (rd_ctrl ? ctrl_readback : 8'h00_00);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      source_select_reg <= fpa_pkg::SOURCE_SELECT_RESET;
    end else if (wr_select_ok) begin
      source_select_reg <= reg_wr_i.data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      manual_duty_force_reg <= fpa_pkg::OVERRIDE_LOCK_RESET[fpa_pkg::MANUAL_DUTY_FORCE];
    end else if (wr_ctrl_ok) begin
      manual_duty_force_reg <= reg_wr_i.data[fpa_pkg::MANUAL_DUTY_FORCE];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      output_polarity_flip_reg <= fpa_pkg::OVERRIDE_LOCK_RESET[fpa_pkg::OUTPUT_POLARITY_FLIP];
    end else if (wr_ctrl_ok) begin
      output_polarity_flip_reg <= reg_wr_i.data[fpa_pkg::OUTPUT_POLARITY_FLIP];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hot_event_hold_enable_reg <= fpa_pkg::OVERRIDE_LOCK_RESET[fpa_pkg::HOT_EVENT_HOLD_ENABLE];
    end else if (wr_ctrl_ok) begin
      hot_event_hold_enable_reg <= reg_wr_i.data[fpa_pkg::HOT_EVENT_HOLD_ENABLE];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      manual_duty_level_reg <= fpa_pkg::OVERRIDE_LOCK_RESET[fpa_pkg::MANUAL_DUTY_LEVEL_HI:
                                                            fpa_pkg::MANUAL_DUTY_LEVEL_LO];
    end else if (wr_ctrl_ok) begin
      manual_duty_level_reg <= reg_wr_i.data[fpa_pkg::MANUAL_DUTY_LEVEL_HI:
                                             fpa_pkg::MANUAL_DUTY_LEVEL_LO];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hot_event_full_hold_reg <= fpa_pkg::OVERRIDE_LOCK_RESET[fpa_pkg::HOT_EVENT_FULL_HOLD];
      duty_in_use_reg         <= '0;
      spin_up_start_reg       <= 1'b0;
    end else begin
      hot_event_full_hold_reg <= hot_event_full_hold_next;
      duty_in_use_reg         <= duty_in_use_next;
      spin_up_start_reg       <= start_spin;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_reg <= '0;
    end else if (pwm_step_tick_i) begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= duty_high ^ output_polarity_flip_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_reg <= 8'h00_00;
      rd_hit_reg  <= 1'b0;
    end else begin
      rd_data_reg <= reg_rd_i.rd_en ? rd_mux : 8'h00_00;
      rd_hit_reg  <= reg_rd_i.rd_en && (rd_select || rd_ctrl);
    end
  end

  assign reg_rd_data_o           = rd_data_reg;
  assign reg_rd_hit_o            = rd_hit_reg;
  assign spin_up_start_o         = spin_up_start_reg;
  assign duty_in_use_o           = duty_in_use_reg;
  assign fan_drive_channel_two_o = drive_reg;

endmodule
`default_nettype wire

// ==== testbench/fpa_checker.sv ====
// Purpose: port assertions for the channel two arbiter
// Assumes: read data one cycle after rd_en
// Notes:   bound at the foot
`timescale 1ns/100ps
`default_nettype none
module fpa_checker (
  input wire logic                 ref_clk_i,
  input wire logic                 rst_b_i,
  input wire fpa_pkg::fpa_reg_wr_s reg_wr_i,
  input wire fpa_pkg::fpa_reg_rd_s reg_rd_i,
  input wire logic [7:0]           reg_rd_data_o,
  input wire logic                 reg_rd_hit_o,
  input wire logic                 spin_up_active_i,
  input wire logic                 spin_up_start_o,
  input wire logic [3:0]           duty_in_use_o,
  input wire logic                 fan_drive_channel_two_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic rd_cd = reg_rd_i.rd_en && reg_rd_i.addr == fpa_pkg::OVERRIDE_LOCK_ADDR;
  wire logic rd_map = rd_cd || reg_rd_i.rd_en && reg_rd_i.addr == fpa_pkg::SOURCE_SELECT_ADDR;
  a_map_rd_hit: assert property (rd_map |=> reg_rd_hit_o)
    else $error("mapped read not answered");
  a_idle_rd_quiet: assert property (!rd_map |=> !reg_rd_hit_o && reg_rd_data_o == 8'h00)
    else $error("read port not quiet");
  a_spin_level_zero: assert property (rd_cd && spin_up_active_i |=> reg_rd_data_o[7:4] == 4'h0)
    else $error("level not zero in spin-up");
  a_level_is_duty: assert property (
    rd_cd && !spin_up_active_i |=> reg_rd_data_o[7:4] == $past(duty_in_use_o))
    else $error("level differs from duty");
  a_hold_full_duty: assert property (
    $past(rd_cd) && reg_rd_data_o[3] |-> duty_in_use_o == fpa_pkg::DUTY_FULL)
    else $error("hold without full duty");
  a_start_on_rise: assert property (
    $past(duty_in_use_o) == 4'h0 && duty_in_use_o != 4'h0 |-> ##[0:1] spin_up_start_o)
    else $error("no spin-up start");
  a_start_one_pulse: assert property (spin_up_start_o |=> !spin_up_start_o)
    else $error("start pulse too long");
  a_full_pin_steady: assert property (
    $past(duty_in_use_o) == fpa_pkg::DUTY_FULL && $past(duty_in_use_o, 2) == fpa_pkg::DUTY_FULL
    && !$past(reg_wr_i.wr_en) && !$past(reg_wr_i.wr_en, 2) && !$past(reg_wr_i.wr_en, 3)
    |-> $stable(fan_drive_channel_two_o))
    else $error("pin toggles at full duty");
  c_spin_read: cover property (rd_cd && spin_up_active_i);
  c_start: cover property (spin_up_start_o);
  c_full: cover property (duty_in_use_o == fpa_pkg::DUTY_FULL);
endmodule
bind fpa_source_arbiter fpa_checker u_chk (.ref_clk_i, .rst_b_i, .reg_wr_i, .reg_rd_i,
  .reg_rd_data_o, .reg_rd_hit_o, .spin_up_active_i, .spin_up_start_o, .duty_in_use_o,
  .fan_drive_channel_two_o);
`default_nettype wire

// ==== testbench/fpa_fan_model.sv ====
// Purpose: fan on the pin, counts driven-high cycles
// Assumes: pin sampled on the rising edge
// Notes:   a real fan filters the pwm; a count is enough
`timescale 1ns/100ps
`default_nettype none
module fpa_fan_model (
  input  wire logic ref_clk_i,
  input  wire logic clear_i,
  input  wire logic pin_i,
  output logic [7:0] high_cnt_o
);
  always_ff @(posedge ref_clk_i) begin
    high_cnt_o <= clear_i ? 8'h00 : high_cnt_o + 8'(pin_i);
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: random and corner stimulus for the channel two arbiter
// Assumes: duty settles two edges after a write
// Notes:   hold is exercised on both cpu alerts
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_b = 1'b0, frz = 1'b0, a1_b = 1'b1, spin = 1'b0, tick = 1'b0;
  logic clr = 1'b1, hit, start, pin, a2_b = 1'b1;
  logic [3:0] zt [4], rp [4], duty, sd = 4'h9, lv;
  logic [7:0] rdat, fan_cnt, d, sel;
  fpa_pkg::fpa_reg_wr_s wr = '0;
  fpa_pkg::fpa_reg_rd_s rd = '0;
  int seed = 32'hb707, miscompares = 0, samples_checked = 0;
  localparam logic [7:0] SS = fpa_pkg::SOURCE_SELECT_ADDR, OL = fpa_pkg::OVERRIDE_LOCK_ADDR;
  always #4 clk = ~clk;
  always @(negedge clk) tick <= ~tick;
  fpa_source_arbiter u_dut (.ref_clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rd_data_o(rdat), .reg_rd_hit_o(hit), .config_freeze_i(frz), .zone_table_duty_i(zt),
    .cpu1_ramp_duty_i(rp[0]), .cpu2_ramp_duty_i(rp[1]), .regulator1_ramp_duty_i(rp[2]),
    .regulator2_ramp_duty_i(rp[3]), .cpu1_thermal_alert_in_b_i(a1_b),
    .cpu2_thermal_alert_in_b_i(a2_b), .spin_up_active_i(spin), .spin_up_duty_i(sd),
    .pwm_step_tick_i(tick), .spin_up_start_o(start), .duty_in_use_o(duty),
    .fan_drive_channel_two_o(pin));
  fpa_fan_model u_fan (.ref_clk_i(clk), .clear_i(clr), .pin_i(pin), .high_cnt_o(fan_cnt));
  function automatic logic [3:0] exp_duty(input logic [7:0] s, input logic f,
                                          input logic [3:0] l);
    logic [3:0] m;
    m = f ? l : 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (s[i] && zt[i] > m) m = zt[i];
      if (s[i+4] && rp[i] > m) m = rp[i];
    end
    return m;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk) wr <= '{1'b1, a, v};
    @(negedge clk) wr <= '0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rreg(input logic [7:0] a);
    @(negedge clk) rd <= '{1'b1, a};
    @(negedge clk) rd <= '0;
    d = rdat;
    chk("hit", {7'h00, a == SS || a == OL}, {7'h00, hit});
  endtask
  task automatic rand_src();
    for (int i = 0; i < 4; i++) begin
      zt[i] = 4'($random(seed));
      rp[i] = 4'($random(seed));
    end
  endtask
  task automatic chk_lvl(input logic [7:0] s, input logic f, input logic [3:0] l);
    rreg(OL);
    chk("level", {4'h0, exp_duty(s, f, l)}, {4'h0, d[7:4]});
    chk("duty", {4'h0, exp_duty(s, f, l)}, {4'h0, duty});
  endtask
  task automatic fan_chk(input logic [7:0] e);
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    repeat (16) @(negedge clk);
    chk("fan high", e, fan_cnt);
  endtask
  task automatic complete_run();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    complete_run();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      zt[i] = 4'h0;
      rp[i] = 4'h0;
    end
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    rreg(SS);
    chk("select reset", fpa_pkg::SOURCE_SELECT_RESET, d);
    rreg(OL);
    chk("control reset", fpa_pkg::OVERRIDE_LOCK_RESET, d);
    rreg(8'h00);
    chk("unmapped", 8'h00, d);
    for (int b = 0; b < 8; b++) begin
      rand_src();
      wreg(SS, 8'h01 << b);
      chk_lvl(8'h01 << b, 1'b0, 4'h0);
    end
    for (int n = 0; n < 24; n++) begin
      sel = (n == 0) ? 8'h00 : 8'($random(seed));
      lv = 4'($random(seed));
      wreg(SS, sel);
      wreg(OL, {lv, 3'b000, n[0]});
      rand_src();
      chk_lvl(sel, n[0], lv);
    end
    spin = 1'b1;
    rreg(OL);
    chk("spin level", 8'h00, {4'h0, d[7:4]});
    chk("spin duty", {4'h0, (sd > exp_duty(sel, 1'b1, lv)) ? sd : exp_duty(sel, 1'b1, lv)},
        {4'h0, duty});
    spin = 1'b0;
    wreg(OL, 8'h04);
    wreg(SS, 8'h10);
    a1_b = 1'b0;
    @(negedge clk) a1_b = 1'b1;
    rreg(OL);
    chk("hold set", 8'hfc, d);
    frz = 1'b1;
    wreg(OL, 8'h00);
    rreg(OL);
    chk("hold cleared", {exp_duty(8'h10, 1'b0, 4'h0), 4'h4}, d);
    frz = 1'b0;
    wreg(OL, 8'h00);
    a1_b = 1'b0;
    @(negedge clk) a1_b = 1'b1;
    rreg(OL);
    chk("no hold", {exp_duty(8'h10, 1'b0, 4'h0), 4'h0}, d);
    wreg(OL, 8'h04);
    wreg(SS, 8'h20);
    a2_b = 1'b0;
    @(negedge clk) a2_b = 1'b1;
    rreg(OL);
    chk("hold cpu2", 8'hfc, d);
    wreg(OL, 8'h00);
    zt[0] = fpa_pkg::DUTY_FULL;
    wreg(SS, 8'h01);
    fan_chk(8'h10);
    wreg(OL, 8'h02);
    fan_chk(8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
